// *** include/overrange_map.svh ***
/*
  register offsets, field positions, reset values and widths for the over-range
  status and auxiliary clock output block.
  assumes: included by bare name from the package and the design modules.
*/
`ifndef OVERRANGE_MAP_SVH
`define OVERRANGE_MAP_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define OVR_SAMPLE_W 9
`define OVR_COUNT_W 8
`define OVR_ADDR_W 8

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OVR_THRESH_OFS 8'h00
`define OVR_PULSE_OFS 8'h04
`define OVR_CLKCTL_OFS 8'h08
`define OVR_STATUS_OFS 8'h0C

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define OVR_CLKCTL_OVERRIDE_BIT 0
`define OVR_CLKCTL_SEL_LSB 1
`define OVR_STATUS_FLAG_LSB 0
`define OVR_STATUS_CLKMODE_BIT 3
`define OVR_STATUS_SEL_LSB 4
`define OVR_STATUS_PD_BIT 6
`define OVR_STATUS_PLL_BIT 7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define OVR_THRESH_RST 9'h1F0
`define OVR_PULSE_RST 8'h04
`define OVR_SEL_RST 2'h0

// ----------------------------------------------------------------------
// clock select codes and bus responses
// ----------------------------------------------------------------------
`define OVR_SEL_FLAG 2'h0
`define OVR_SEL_DIV1 2'h1
`define OVR_SEL_DIV2 2'h2
`define OVR_SEL_DIV4 2'h3
`define AXI_RESP_OKAY 2'b00
`define AXI_RESP_SLVERR 2'b10

`endif

// *** include/overrange_pkg.sv ***
/*
  types shared by the over-range status and auxiliary clock output block.
  assumes: overrange_map.svh sits on the include path.
*/
`include "overrange_map.svh"

package overrange_pkg;

  // ----------------------------------------------------------------------
  // software settings
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [`OVR_SAMPLE_W-1:0] overrangeThreshold;
    logic [`OVR_COUNT_W-1:0] overrangeMinPulseCount;
    logic selOverride;
    logic [1:0] auxClockSelectReg;
  } cfg_t;

  // ----------------------------------------------------------------------
  // one converter sample
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [`OVR_SAMPLE_W-1:0] data;
  } sample_t;

  // ----------------------------------------------------------------------
  // what the channel C pin carries
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PIN_FLAG,
    PIN_CLOCK,
    PIN_STOPPED
  } pin_mode_t;

endpackage

// *** logic/overrange_hold.sv ***
/*
  one channel of over-range detection with a minimum-length hold.
  assumes: samples synchronous to core_clk; settings stable or changed by software.
*/
`timescale 1ns/1ps
`include "overrange_map.svh"

module overrange_hold (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire overrange_pkg::sample_t sample,
  input wire logic [`OVR_SAMPLE_W-1:0] threshold,
  input wire logic [`OVR_COUNT_W-1:0] minPulse,
  output logic flag
);

  // ----------------------------------------------------------------------
  // compare and reload
  // ----------------------------------------------------------------------
  logic [`OVR_COUNT_W-1:0] holdCnt_r;
  logic [`OVR_COUNT_W-1:0] holdCnt_nxt;
  logic flag_r;
  logic flag_nxt;
  wire logic exceed = enable && sample.valid && (sample.data > threshold);
  wire logic [`OVR_COUNT_W-1:0] reloadVal = (minPulse == '0) ? `OVR_COUNT_W'(1) : minPulse;

  assign holdCnt_nxt = !enable ? '0 :
                       exceed ? reloadVal :
                       (holdCnt_r != '0) ? holdCnt_r - `OVR_COUNT_W'(1) : '0;
  assign flag_nxt = exceed || (enable && holdCnt_r > `OVR_COUNT_W'(1));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      holdCnt_r <= '0;
      flag_r <= 1'b0;
    end else begin
      holdCnt_r <= holdCnt_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign flag = flag_r;

endmodule // overrange_hold

// *** logic/overrange_status_clock_out.sv ***
/*
  over-range status outputs for channels A, B, C with the channel C pin shared
  as an auxiliary clock output, plus the repeated reference clock; AXI4-Lite
  register slave.
  assumes: all inputs synchronous to core_clk; the reference clocks arrive as
  sampled levels well below core_clk / 2.
*/
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "overrange_map.svh"

module overrange_status_clock_out #(
  parameter int CHANNEL_COUNT = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire overrange_pkg::sample_t chanASample,
  input wire overrange_pkg::sample_t chanBSample,
  input wire overrange_pkg::sample_t chanCSample,
  input wire logic refClockDiffIn,
  input wire logic refClockSeIn,
  input wire logic refClockSeSel,
  input wire logic pllEnable,
  input wire logic powerDownPin,
  input wire logic [1:0] auxClockSelect,
  output logic chanAOverrangeOut,
  output logic chanBOverrangeOut,
  output logic chanCOverrangeOrClockOut,
  output logic refClockRepeatOut,
  input wire logic [`OVR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`OVR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------------
  // address decode helper
  // ----------------------------------------------------------------------
  function automatic logic isMapped(input logic [`OVR_ADDR_W-1:0] a);
    isMapped = (a == `OVR_THRESH_OFS) || (a == `OVR_PULSE_OFS) ||
               (a == `OVR_CLKCTL_OFS) || (a == `OVR_STATUS_OFS);
  endfunction

  // ----------------------------------------------------------------------
  // register bus: write path
  // ----------------------------------------------------------------------
  overrange_pkg::cfg_t cfg_r;
  overrange_pkg::cfg_t cfg_nxt;
  logic [`OVR_ADDR_W-1:0] wAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic awHeld_r;
  logic wHeld_r;
  logic awReady_r;
  logic wReady_r;
  logic bValid_r;
  logic [1:0] bResp_r;

  wire logic awTake = s_axi_awvalid && awReady_r;
  wire logic wTake = s_axi_wvalid && wReady_r;
  wire logic doWrite = awHeld_r && wHeld_r && !bValid_r;
  wire logic bDone = bValid_r && s_axi_bready;

  always_comb begin
    cfg_nxt = cfg_r;
    if (doWrite && wAddr_r == `OVR_THRESH_OFS) begin
      if (wStrb_r[0]) cfg_nxt.overrangeThreshold[7:0] = wData_r[7:0];
      if (wStrb_r[1]) cfg_nxt.overrangeThreshold[8] = wData_r[8];
    end
    if (doWrite && wAddr_r == `OVR_PULSE_OFS && wStrb_r[0]) begin
      cfg_nxt.overrangeMinPulseCount = wData_r[`OVR_COUNT_W-1:0];
    end
    if (doWrite && wAddr_r == `OVR_CLKCTL_OFS && wStrb_r[0]) begin
      cfg_nxt.selOverride = wData_r[`OVR_CLKCTL_OVERRIDE_BIT];
      cfg_nxt.auxClockSelectReg = wData_r[`OVR_CLKCTL_SEL_LSB +: 2];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= '{`OVR_THRESH_RST, `OVR_PULSE_RST, 1'b0, `OVR_SEL_RST};
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wAddr_r <= '0;
      wData_r <= '0;
      wStrb_r <= '0;
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awReady_r <= 1'b1;
      wReady_r <= 1'b1;
      bValid_r <= 1'b0;
      bResp_r <= `AXI_RESP_OKAY;
    end else begin
      if (awTake) begin
        wAddr_r <= s_axi_awaddr;
        awHeld_r <= 1'b1;
        awReady_r <= 1'b0;
      end
      if (wTake) begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        wHeld_r <= 1'b1;
        wReady_r <= 1'b0;
      end
      if (doWrite) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        bValid_r <= 1'b1;
        bResp_r <= isMapped(wAddr_r) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end
      if (bDone) begin
        bValid_r <= 1'b0;
        awReady_r <= 1'b1;
        wReady_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // over-range detection per channel
  // ----------------------------------------------------------------------
  logic flagA;
  logic flagB;
  logic flagC;
  wire logic chanBPresent = (CHANNEL_COUNT >= 2);
  wire logic chanCPresent = (CHANNEL_COUNT >= 4);

  overrange_hold holdA (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .enable(1'b1),
    .sample(chanASample),
    .threshold(cfg_r.overrangeThreshold),
    .minPulse(cfg_r.overrangeMinPulseCount),
    .flag(flagA)
  );

  overrange_hold holdB (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .enable(chanBPresent),
    .sample(chanBSample),
    .threshold(cfg_r.overrangeThreshold),
    .minPulse(cfg_r.overrangeMinPulseCount),
    .flag(flagB)
  );

  overrange_hold holdC (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .enable(chanCPresent),
    .sample(chanCSample),
    .threshold(cfg_r.overrangeThreshold),
    .minPulse(cfg_r.overrangeMinPulseCount),
    .flag(flagC)
  );

  // ----------------------------------------------------------------------
  // reference clock repeat and dividers
  // ----------------------------------------------------------------------
  logic refRepeat_r;
  logic div2_r;
  logic div4_r;
  wire logic refSelected = refClockSeSel ? refClockSeIn : refClockDiffIn;
  wire logic refRise = refSelected && !refRepeat_r;
  wire logic div2Rise = refRise && !div2_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      refRepeat_r <= 1'b0;
      div2_r <= 1'b0;
      div4_r <= 1'b0;
    end else begin
      refRepeat_r <= refSelected;
      if (refRise) div2_r <= !div2_r;
      if (div2Rise) div4_r <= !div4_r;
    end
  end

  // ----------------------------------------------------------------------
  // channel C pin mode and output select
  // ----------------------------------------------------------------------
  wire logic [1:0] effSel = cfg_r.selOverride ? cfg_r.auxClockSelectReg : auxClockSelect;
  wire logic clockWanted = (effSel != `OVR_SEL_FLAG) && pllEnable;
  wire overrange_pkg::pin_mode_t pinMode = !clockWanted ? overrange_pkg::PIN_FLAG :
                                           powerDownPin ? overrange_pkg::PIN_STOPPED :
                                           overrange_pkg::PIN_CLOCK;
  logic divClock;
  logic chanCPin;

  always_comb begin
    case (effSel)
      `OVR_SEL_DIV1: divClock = refSelected;
      `OVR_SEL_DIV2: divClock = refRise ? !div2_r : div2_r;
      `OVR_SEL_DIV4: divClock = div2Rise ? !div4_r : div4_r;
      default: divClock = 1'b0;
    endcase
  end

  always_comb begin
    case (pinMode)
      overrange_pkg::PIN_FLAG: chanCPin = flagC;
      overrange_pkg::PIN_CLOCK: chanCPin = divClock;
      overrange_pkg::PIN_STOPPED: chanCPin = 1'b0;
      default: chanCPin = 1'b0;
    endcase
  end

  logic outA_r;
  logic outB_r;
  logic outC_r;
  logic outRef_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      outA_r <= 1'b0;
      outB_r <= 1'b0;
      outC_r <= 1'b0;
      outRef_r <= 1'b0;
    end else begin
      outA_r <= flagA;
      outB_r <= flagB;
      outC_r <= chanCPin;
      outRef_r <= refSelected && !powerDownPin;
    end
  end

  assign chanAOverrangeOut = outA_r;
  assign chanBOverrangeOut = outB_r;
  assign chanCOverrangeOrClockOut = outC_r;
  assign refClockRepeatOut = outRef_r;

  // ----------------------------------------------------------------------
  // register bus: read path
  // ----------------------------------------------------------------------
  logic arReady_r;
  logic rValid_r;
  logic [31:0] rData_r;
  logic [1:0] rResp_r;
  wire logic arTake = s_axi_arvalid && arReady_r;
  wire logic [31:0] statusWord = {24'h00_0000, pllEnable, powerDownPin, effSel,
                                  pinMode == overrange_pkg::PIN_CLOCK, flagC, flagB, flagA};
  wire logic [31:0] readWord =
    (s_axi_araddr == `OVR_THRESH_OFS) ? {23'h00_0000, cfg_r.overrangeThreshold} :
    (s_axi_araddr == `OVR_PULSE_OFS) ? {24'h00_0000, cfg_r.overrangeMinPulseCount} :
    (s_axi_araddr == `OVR_CLKCTL_OFS) ? {29'h0000_0000, cfg_r.auxClockSelectReg, cfg_r.selOverride} :
    (s_axi_araddr == `OVR_STATUS_OFS) ? statusWord : 32'h0000_0000;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      arReady_r <= 1'b1;
      rValid_r <= 1'b0;
      rData_r <= '0;
      rResp_r <= `AXI_RESP_OKAY;
    end else begin
      if (arTake) begin
        arReady_r <= 1'b0;
        rValid_r <= 1'b1;
        rData_r <= readWord;
        rResp_r <= isMapped(s_axi_araddr) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (rValid_r && s_axi_rready) begin
        rValid_r <= 1'b0;
        arReady_r <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awReady_r;
  assign s_axi_wready = wReady_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;

endmodule // overrange_status_clock_out

// *** sim/overrange_status_clock_out_bench.sv ***
/*
  self-checking bench for the over-range status and clock output block.
  assumes: partner model makes reference levels of period 8 and 12 cycles.
*/
`timescale 1ns/1ps
`include "overrange_map.svh"
module overrange_status_clock_out_bench;
  logic core_clk, rst_n = 0, refClockSeSel = 0, pllEnable = 1, powerDownPin = 0, clr = 0;
  logic [1:0] auxClockSelect = 2'h1, smpCh = 2'h0, r;
  overrange_pkg::sample_t smp = '0;
  wire overrange_pkg::sample_t chanASample = (smpCh == 2'h0) ? smp : '0;
  wire overrange_pkg::sample_t chanBSample = (smpCh == 2'h1) ? smp : '0;
  wire overrange_pkg::sample_t chanCSample = (smpCh == 2'h2) ? smp : '0;
  wire logic refClockDiffIn, refClockSeIn;
  wire logic [7:0] pinRises;
  logic chanAOverrangeOut, chanBOverrangeOut, chanCOverrangeOrClockOut, refClockRepeatOut, ok;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, n;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [2:0] flags = {chanCOverrangeOrClockOut, chanBOverrangeOut, chanAOverrangeOut};
  int error_cnt = 0, n_checks = 0;
  overrange_status_clock_out #(.CHANNEL_COUNT(4)) dut (
    .core_clk, .rst_n, .chanASample, .chanBSample, .chanCSample, .refClockDiffIn, .refClockSeIn,
    .refClockSeSel, .pllEnable, .powerDownPin, .auxClockSelect, .chanAOverrangeOut, .chanBOverrangeOut,
    .chanCOverrangeOrClockOut, .refClockRepeatOut, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  overrange_sys_partner sys (.core_clk, .rst_n, .clr, .pin(chanCOverrangeOrClockOut),
    .refDiff(refClockDiffIn), .refSe(refClockSeIn), .pinRises);
  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    forever begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    forever begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge core_clk);
  endtask
  task automatic rises(input logic [7:0] e);
    clr <= 1;
    @(posedge core_clk);
    clr <= 0;
    repeat (96) @(posedge core_clk);
    ok = (pinRises + 8'h01 >= e) && (pinRises <= e);
  endtask
  task automatic pulse(input logic [1:0] ch, input logic [8:0] v, input int g);
    smpCh <= ch;
    smp <= {1'b1, v};
    n = 8'h00;
    @(posedge core_clk);
    for (int i = 0; i < 48; i++) begin
      smp.valid <= (i + 1 == g);
      @(posedge core_clk);
      n = n + {7'h00, flags[ch]};
    end
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic tRegs();
    rd(`OVR_THRESH_OFS); chk(d, 32'h0000_01F0, "threshold reset");
    chk({30'h0, r}, {30'h0, `AXI_RESP_OKAY}, "read response");
    rd(`OVR_PULSE_OFS); chk(d, 32'h0000_0004, "pulse reset");
    rd(8'h10); chk({r, d[29:0]}, {`AXI_RESP_SLVERR, 30'h0}, "unmapped read");
    wr(8'h10, 32'h0000_0055); chk({30'h0, r}, {30'h0, `AXI_RESP_SLVERR}, "unmapped write");
  endtask
  task automatic tFlags();
    auxClockSelect <= `OVR_SEL_FLAG;
    wr(`OVR_THRESH_OFS, 32'h0000_0100);
    wr(`OVR_PULSE_OFS, 32'h0000_0006);
    for (int c = 0; c < 3; c++) begin
      pulse(c[1:0], 9'h101, 0); chk(n, 6, "minimum pulse");
      pulse(c[1:0], 9'h100, 0); chk(n, 0, "equal not over");
    end
    pulse(2'h0, 9'h1FF, 5); chk(n, 11, "retrigger");
    wr(`OVR_PULSE_OFS, 32'h0000_0000);
    pulse(2'h0, 9'h1FF, 0); chk(n, 1, "zero count");
  endtask
  task automatic tClk();
    for (int s = 1; s < 4; s++) begin
      wr(`OVR_CLKCTL_OFS, {29'h0, s[1:0], 1'b1});
      chk({30'h0, r}, {30'h0, `AXI_RESP_OKAY}, "write response");
      rd(`OVR_CLKCTL_OFS); chk(d, {29'h0, s[1:0], 1'b1}, "select readback");
      rd(`OVR_STATUS_OFS); chk(d, {24'h00_0000, 2'h2, s[1:0], 4'h8}, "status word");
      rises(8'd12 >> (s - 1)); chk(ok, 1, "divided clock");
    end
    pllEnable <= 0;
    rises(0); chk(ok, 1, "pll off");
    pllEnable <= 1;
    wr(`OVR_CLKCTL_OFS, 32'h0000_0001);
    rises(0); chk(ok, 1, "select zero");
    wr(`OVR_CLKCTL_OFS, 32'h0000_0003);
    refClockSeSel <= 1;
    rises(8); chk(ok, 1, "single ended ref");
    powerDownPin <= 1;
    rises(0); chk(ok, 1, "power down");
    chk(refClockRepeatOut, 0, "ref stopped");
  endtask
  task automatic summarize();
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    core_clk = 0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #50000;
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1;
    @(posedge core_clk);
    rises(12); chk(ok, 1, "strap clock at start");
    tRegs();
    tFlags();
    tClk();
    summarize();
  end
endmodule // overrange_status_clock_out_bench

// *** sim/overrange_status_clock_out_sva.sv ***
/*
  checker for the over-range flags and the channel C clock pin.
  assumes: bench writes with all byte strobes; bound to the top module.
*/
`timescale 1ns/1ps
`include "overrange_map.svh"
module overrange_status_clock_out_sva #(
  parameter int CHANNEL_COUNT = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire overrange_pkg::sample_t chanASample,
  input wire overrange_pkg::sample_t chanBSample,
  input wire overrange_pkg::sample_t chanCSample,
  input wire logic refClockDiffIn,
  input wire logic refClockSeIn,
  input wire logic refClockSeSel,
  input wire logic pllEnable,
  input wire logic powerDownPin,
  input wire logic [1:0] auxClockSelect,
  input wire logic chanAOverrangeOut,
  input wire logic chanBOverrangeOut,
  input wire logic chanCOverrangeOrClockOut,
  input wire logic refClockRepeatOut,
  input wire logic [`OVR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  logic [7:0] wa_r;
  logic [31:0] wd_r;
  logic [8:0] thr_r, sinceA_r;
  logic [7:0] pul_r;
  logic [2:0] ctl_r;
  wire logic selRef = refClockSeSel ? refClockSeIn : refClockDiffIn;
  wire logic [1:0] effSel = ctl_r[0] ? ctl_r[2:1] : auxClockSelect;
  wire logic clkMode = (effSel != `OVR_SEL_FLAG) && pllEnable;
  wire logic [8:0] effN = (pul_r == 8'h00) ? 9'h001 : {1'b0, pul_r};
  wire logic exA = chanASample.valid && (chanASample.data > thr_r);
  wire logic exB = chanBSample.valid && (chanBSample.data > thr_r) && (CHANNEL_COUNT >= 2);
  wire logic exC = chanCSample.valid && (chanCSample.data > thr_r) && (CHANNEL_COUNT == 4);
  // ----------------------------------------------------------------------
  // shadow of the written settings
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {wa_r, wd_r, ctl_r} <= '0;
      thr_r <= `OVR_THRESH_RST;
      pul_r <= `OVR_PULSE_RST;
      sinceA_r <= 9'h1FF;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wa_r <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata;
      if (s_axi_bvalid && s_axi_bready && s_axi_bresp == `AXI_RESP_OKAY) begin
        if (wa_r == `OVR_THRESH_OFS) thr_r <= wd_r[8:0];
        if (wa_r == `OVR_PULSE_OFS) pul_r <= wd_r[7:0];
        if (wa_r == `OVR_CLKCTL_OFS) ctl_r <= wd_r[2:0];
      end
      sinceA_r <= exA ? 9'h000 : sinceA_r + {8'h00, sinceA_r != 9'h1FF};
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_flag_a_rise: assert property (
    exA |-> ##2 chanAOverrangeOut) else $error("flag A late");
  chk_flag_b_rise: assert property (
    exB |-> ##2 chanBOverrangeOut) else $error("flag B late");
  chk_flag_c_rise: assert property (
    exC && !clkMode ##1 !clkMode |-> ##1 chanCOverrangeOrClockOut) else $error("flag C late");
  chk_pulse_len_a: assert property (
    $fell(chanAOverrangeOut) |-> sinceA_r == effN + 9'h001) else $error("flag A length");
  chk_pd_clock_stop: assert property (
    (powerDownPin && clkMode)[*3] |-> !chanCOverrangeOrClockOut) else $error("clock not stopped");
  chk_pd_ref_stop: assert property (
    powerDownPin[*2] |-> !refClockRepeatOut) else $error("reference not stopped");
  chk_ref_repeat: assert property (
    (!powerDownPin && selRef == $past(selRef))[*3] |-> refClockRepeatOut == selRef) else $error("reference copy");
  chk_div1_copy: assert property (
    (clkMode && effSel == `OVR_SEL_DIV1 && !powerDownPin && selRef == $past(selRef))[*4]
    |-> chanCOverrangeOrClockOut == selRef) else $error("direct clock copy");
  cov_flag_a: cover property ($fell(chanAOverrangeOut));
  cov_div4: cover property (clkMode && effSel == `OVR_SEL_DIV4 && $rose(chanCOverrangeOrClockOut));
  cov_pd: cover property (powerDownPin && clkMode);
endmodule // overrange_status_clock_out_sva

bind overrange_status_clock_out overrange_status_clock_out_sva #(.CHANNEL_COUNT(CHANNEL_COUNT)) chk (
  .core_clk, .rst_n, .chanASample, .chanBSample, .chanCSample, .refClockDiffIn, .refClockSeIn,
  .refClockSeSel, .pllEnable, .powerDownPin, .auxClockSelect, .chanAOverrangeOut, .chanBOverrangeOut,
  .chanCOverrangeOrClockOut, .refClockRepeatOut, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready
);

// *** sim/overrange_sys_partner.sv ***
/*
  system side: makes the two reference clock levels and counts rising edges
  seen on the channel C pin.
  assumes: one core_clk domain; references far slower than core_clk.
*/
`timescale 1ns/1ps
module overrange_sys_partner (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic pin,
  output logic refDiff,
  output logic refSe,
  output logic [7:0] pinRises
);
  logic [4:0] ph_r;
  logic pinPrev_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {ph_r, refDiff, refSe, pinPrev_r, pinRises} <= '0;
    end else begin
      ph_r <= (ph_r == 5'h17) ? 5'h00 : ph_r + 5'h01;
      refDiff <= ph_r[2];
      refSe <= (ph_r % 5'h0C) >= 5'h06;
      pinPrev_r <= pin;
      pinRises <= clr ? 8'h00 : pinRises + {7'h00, pin && !pinPrev_r};
    end
  end
endmodule // overrange_sys_partner
